// file: psq_sequencer.sv
// Purpose: program counter, return stack and table read sequencing
// Assumes: program memory answers a fetch address with data one cycle later
// Notes: register reads return data one cycle after the strobe
module psq_sequencer
	import psq_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// instruction execution unit
	input wire psq_instr_t instr,
	input wire logic skipTaken,
	input wire logic intRequest,
	input wire logic [PC_W-1:0] intVector,
	input wire logic aluDone,
	input wire logic [3:0] aluFlags,
	output logic instrReady,
	output logic intAck,
	output logic [3:0] statusFlags,
	// program memory
	output logic [PC_W-1:0] fetchAddr,
	input wire logic [WORD_W-1:0] fetchData,
	// data memory write of table low byte
	output psq_dwrite_t tableWrite,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// state visible to the core
	output logic [PC_W-1:0] pcValue,
	output logic [LOW_W-1:0] tableHighByteLatch
);
	psq_state_t state_r, state_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [PC_W-1:0] stack_r [DEPTH];
	logic [SP_W-1:0] sp_r, sp_nxt;
	logic [LOW_W-1:0] table_high_byte_latch_r;
	logic [3:0] status_r;
	logic [7:0] rdData_r;
	logic [11:0] tblDest_r;
	logic tblSector0_r;
	psq_dwrite_t tableWrite_r;
	logic intAck_r;
	logic stackFull;
	logic doPush, doPop, doInt, pclWrite;
	logic [PC_W-1:0] tableAddr;

	function automatic logic isTable(input psq_cmd_t c);
		return c == CMD_TABLE || c == CMD_TABLE_LAST || c == CMD_EXT_TABLE ||
			c == CMD_EXT_TABLE_LAST;
	endfunction

	function automatic logic isExtTable(input psq_cmd_t c);
		return c == CMD_EXT_TABLE || c == CMD_EXT_TABLE_LAST;
	endfunction

	// tied to the depth parameter so a stack up to 7 deep (the 3-bit SP_W limit) still fills at its last level
	assign stackFull = (sp_r == SP_W'(DEPTH));
	// a full stack leaves the request pending until a return frees a level
	assign doInt = intRequest && !stackFull && state_r == ST_RUN;
	assign pclWrite = regWr && regAddr == REG_PC_LOW_BYTE;
	// a pc low write outranks the command, so a call beside it must not push
	assign doPush = state_r == ST_RUN && (doInt || (!pclWrite && instr.cmd == CMD_CALL));
	assign doPop = state_r == ST_RUN && !doInt && !pclWrite &&
		(instr.cmd == CMD_RETURN || instr.cmd == CMD_INT_RETURN);
	// pointer high bits beyond the pc width are dropped
	assign tableAddr = {instr.tblHigh[HIGH_W-1:0], instr.tblLow};
	assign instrReady = (state_r == ST_RUN);

	always_comb begin
		state_nxt = ST_RUN;
		pc_nxt = pc_r;
		if (state_r == ST_RUN) begin
			if (doInt) begin
				pc_nxt = intVector;
				state_nxt = ST_DUMMY;
			end else if (pclWrite) begin
				pc_nxt = {pc_r[PC_W-1:LOW_W], regWrData};
				state_nxt = ST_DUMMY;
			end else begin
				case (instr.cmd)
					CMD_JUMP, CMD_CALL: begin
						pc_nxt = instr.target;
						state_nxt = ST_DUMMY;
					end
					CMD_RETURN, CMD_INT_RETURN: begin
						// an empty stack has no entry to pop; step on instead of reading junk
						if (sp_r == SP_EMPTY) begin
							pc_nxt = pc_r + PC_ONE;
						end else begin
							pc_nxt = stack_r[sp_r - SP_ONE];
						end
						state_nxt = ST_DUMMY;
					end
					CMD_SKIP: begin
						pc_nxt = pc_r + PC_ONE;
						if (skipTaken) begin
							state_nxt = ST_DUMMY;
						end
					end
					CMD_TABLE, CMD_TABLE_LAST, CMD_EXT_TABLE, CMD_EXT_TABLE_LAST: begin
						state_nxt = ST_TABLE;
					end
					CMD_HOLD: begin
						pc_nxt = pc_r;
					end
					default: begin
						pc_nxt = pc_r + PC_ONE;
					end
				endcase
			end
		end else if (state_r == ST_DUMMY) begin
			// the discarded prefetch slot; fetch at the new pc
			pc_nxt = pc_r + PC_ONE;
		end else begin
			pc_nxt = pc_r + PC_ONE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_RUN;
			pc_r <= RESET_VECTOR;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
		end
	end

	// stack storage; a push on a full stack shifts the oldest entry out
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : gStack
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					stack_r[gi] <= RESET_VECTOR;
				end else if (doPush) begin
					if (stackFull) begin
						if (gi == DEPTH - 1) begin
							stack_r[gi] <= pc_r;
						end else begin
							stack_r[gi] <= stack_r[gi + 1];
						end
					end else if (sp_r == SP_W'(gi)) begin
						stack_r[gi] <= pc_r;
					end
				end
			end
		end
	endgenerate

	always_comb begin
		sp_nxt = sp_r;
		if (doPush && !stackFull) begin
			sp_nxt = sp_r + SP_ONE;
		end else if (doPop && sp_r != SP_EMPTY) begin
			sp_nxt = sp_r - SP_ONE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sp_r <= SP_EMPTY;
		end else begin
			sp_r <= sp_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			intAck_r <= 1'b0;
		end else begin
			intAck_r <= doInt;
		end
	end

	// table read: address in first cycle, word captured in second
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tblDest_r <= 12'h000;
			tblSector0_r <= 1'b0;
		end else if (state_r == ST_RUN && isTable(instr.cmd)) begin
			// standard forms reach sector 0 only
			tblSector0_r <= !isExtTable(instr.cmd);
			tblDest_r <= instr.destAddr;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			table_high_byte_latch_r <= 8'h00;
			tableWrite_r <= '0;
		end else begin
			tableWrite_r.valid <= 1'b0;
			if (state_r == ST_TABLE) begin
				table_high_byte_latch_r <= fetchData[WORD_W-1:LOW_W];
				tableWrite_r.valid <= 1'b1;
				tableWrite_r.addr <= tblSector0_r ? {4'h0, tblDest_r[7:0]} : tblDest_r;
				tableWrite_r.data <= fetchData[LOW_W-1:0];
			end else if (regWr && regAddr == REG_TABLE_HIGH) begin
				table_high_byte_latch_r <= regWrData;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_r <= 4'h0;
		end else if (aluDone) begin
			status_r <= aluFlags;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdData_r <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				REG_PC_LOW_BYTE: rdData_r <= pc_r[LOW_W-1:0];
				REG_TABLE_HIGH: rdData_r <= table_high_byte_latch_r;
				default: rdData_r <= 8'h00;
			endcase
		end else begin
			rdData_r <= 8'h00;
		end
	end

	// a table fetch borrows the bus for one cycle; pc is parked meanwhile
	assign fetchAddr = (state_r == ST_RUN && isTable(instr.cmd)) ? tableAddr : pc_r;
	assign pcValue = pc_r;
	assign tableHighByteLatch = table_high_byte_latch_r;
	assign tableWrite = tableWrite_r;
	assign intAck = intAck_r;
	assign statusFlags = status_r;
	assign regRdData = rdData_r;
endmodule

// file: psq_pkg.sv
// Purpose: shared constants and types for the program sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: command codes are local to this block
package psq_pkg;
	localparam int PC_W = 13;
	localparam int LOW_W = 8;
	localparam int HIGH_W = PC_W - LOW_W;
	localparam int WORD_W = 16;
	localparam int STACK_DEPTH = 6;
	localparam int SP_W = 3;
	localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [SP_W-1:0] SP_EMPTY = 3'h0;
	localparam logic [SP_W-1:0] SP_FULL = 3'h6;
	localparam logic [SP_W-1:0] SP_ONE = 3'h1;
	localparam logic [7:0] REG_PC_LOW_BYTE = 8'h06;
	localparam logic [7:0] REG_TABLE_HIGH = 8'h08;
	localparam logic [7:0] REG_STACK_STAT = 8'h0B;

	typedef enum logic [3:0] {
		CMD_NEXT = 4'h0,
		CMD_JUMP = 4'h1,
		CMD_CALL = 4'h2,
		CMD_RETURN = 4'h3,
		CMD_INT_RETURN = 4'h4,
		CMD_SKIP = 4'h5,
		CMD_TABLE = 4'h6,
		CMD_TABLE_LAST = 4'h7,
		CMD_EXT_TABLE = 4'h8,
		CMD_EXT_TABLE_LAST = 4'h9,
		CMD_HOLD = 4'hF
	} psq_cmd_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_DUMMY = 2'b01,
		ST_TABLE = 2'b10
	} psq_state_t;

	typedef struct packed {
		psq_cmd_t cmd;
		logic [PC_W-1:0] target;
		logic [LOW_W-1:0] tblLow;
		logic [LOW_W-1:0] tblHigh;
		logic [11:0] destAddr;
	} psq_instr_t;

	typedef struct packed {
		logic valid;
		logic [11:0] addr;
		logic [LOW_W-1:0] data;
	} psq_dwrite_t;
endpackage

// file: psq_checker.sv
// Purpose: port checks of the program sequencer
// Assumes: bound to psq_sequencer
// Notes: interrupt and pc-low-write edges stay out of plain steps
module psq_checker
	import psq_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// execution side
	input wire psq_instr_t instr,
	input wire logic skipTaken,
	input wire logic intRequest,
	input wire logic [PC_W-1:0] intVector,
	input wire logic instrReady,
	input wire logic intAck,
	input wire logic [PC_W-1:0] pcValue,
	// memory and registers
	input wire logic [PC_W-1:0] fetchAddr,
	input wire logic [WORD_W-1:0] fetchData,
	input wire psq_dwrite_t tableWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic [LOW_W-1:0] tableHighByteLatch
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic pclWr;
	logic quiet;
	assign pclWr = instrReady && !intRequest && regWr && regAddr == REG_PC_LOW_BYTE;
	assign quiet = instrReady && !intRequest && !pclWr;
	AST_STEP: assert property (quiet && instr.cmd == CMD_NEXT
		|=> pcValue == $past(pcValue) + PC_ONE) else $error("pc step");
	AST_JUMP: assert property (quiet && instr.cmd == CMD_JUMP
		|=> pcValue == $past(instr.target) && !instrReady) else $error("jump");
	AST_PCL: assert property (pclWr |=> !instrReady
		&& pcValue == ($past(pcValue) & 13'h1F00 | 13'($past(regWrData)))) else $error("pcl");
	AST_SKIP: assert property (quiet && instr.cmd == CMD_SKIP && skipTaken
		|=> !instrReady) else $error("skip");
	AST_TABLE: assert property (quiet && instr.cmd == CMD_TABLE
		|-> fetchAddr == {instr.tblHigh[HIGH_W-1:0], instr.tblLow} ##1 !instrReady
		##1 tableWrite.valid) else $error("table");
	AST_TDATA: assert property (tableWrite.valid
		|-> {tableHighByteLatch, tableWrite.data} == $past(fetchData)) else $error("tdata");
	AST_DEST: assert property (tableWrite.valid && $past(instr.cmd, 2) == CMD_TABLE
		|-> tableWrite.addr[11:8] == 4'h0) else $error("dest");
	AST_INT: assert property (intAck |-> $past(intRequest) && pcValue == intVector)
		else $error("int");
	C_INT: cover property (intAck);
	C_TBL: cover property (tableWrite.valid);
	C_CALL: cover property (quiet && instr.cmd == CMD_CALL);
endmodule

// file: psq_pmem_model.sv
// Purpose: program memory facing the sequencer
// Assumes: word answered one cycle after its address
// Notes: word is a pattern of its address so the bench can predict it
module psq_pmem_model (
	// clock
	input wire logic clk_sys,
	// fetch port
	input wire logic [12:0] fetchAddr,
	output logic [15:0] fetchData
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge clk_sys) begin
		fetchData <= {3'h5, fetchAddr};
	end
endmodule

// file: psq_tb.sv
// Purpose: self-checking bench of the program sequencer
// Assumes: hold is the idle command so pc moves only when told
// Notes: pointer bytes fixed; high pointer has bits above the pc width
module tb import psq_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 0, rst = 1, skipTaken = 1, intRequest = 0, aluDone = 0;
	logic regWr = 0, regRd = 0, instrReady, intAck;
	logic [3:0] aluFlags = 4'h0, statusFlags;
	logic [7:0] regAddr = 8'h06, regWrData = 8'h56, regRdData, tableHighByteLatch;
	logic [12:0] intVector = 13'h0004, fetchAddr, pcValue, q;
	logic [15:0] fetchData;
	logic [12:0] p [7];
	psq_instr_t instr = '{CMD_HOLD, 13'h0000, 8'h06, 8'hFF, 12'h3A5};
	psq_dwrite_t tableWrite;
	int miscompares = 0, total_checks = 0, cyc = 0;
	psq_sequencer u_dut (.*);
	psq_pmem_model u_mem (.*);
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t %h %h", $time, s, e);
		end
	endtask
	task automatic summarize();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// q keeps the pc seen in the cycle the command was taken
	task automatic iss(input psq_cmd_t c, input logic [12:0] t);
		@(posedge clk_sys) instr.cmd <= c;
		instr.target <= t;
		@(negedge clk_sys);
		for (int n = 0; n < 9 && instrReady !== 1'b1; n++) @(negedge clk_sys);
		q = pcValue;
		@(posedge clk_sys) instr.cmd <= CMD_HOLD;
		@(negedge clk_sys);
	endtask
	task automatic t_flow();
		chk(pcValue, RESET_VECTOR);
		@(posedge clk_sys) regRd <= 1'b1;
		@(posedge clk_sys) regRd <= 1'b0;
		@(negedge clk_sys) chk(regRdData, 8'h00);
		iss(CMD_NEXT, 13'h0000);
		chk(pcValue, q + PC_ONE);
		iss(CMD_JUMP, 13'h1234);
		chk(pcValue, 13'h1234);
		@(posedge clk_sys) regWr <= 1'b1;
		@(posedge clk_sys) regWr <= 1'b0;
		@(negedge clk_sys) chk(pcValue, 13'h1256);
		chk(instrReady, 1'b0);
		iss(CMD_SKIP, 13'h0000);
		chk(instrReady, 1'b0);
		@(posedge clk_sys) aluDone <= 1'b1;
		aluFlags <= 4'h9;
		@(posedge clk_sys) aluDone <= 1'b0;
		@(negedge clk_sys) chk(statusFlags, 4'h9);
	endtask
	// seventh call overflows, so the oldest saved pc never comes back
	task automatic t_stack();
		for (int i = 0; i < 7; i++) begin
			iss(CMD_CALL, 13'(256 * (i + 1)));
			p[i] = q;
		end
		@(posedge clk_sys) intRequest <= 1'b1;
		repeat (4) @(negedge clk_sys) chk(intAck, 1'b0);
		iss(CMD_RETURN, 13'h0000);
		chk(pcValue, p[6]);
		for (int n = 0; n < 9 && intAck !== 1'b1; n++) begin
			q = pcValue;
			@(negedge clk_sys);
		end
		chk(pcValue, intVector);
		@(posedge clk_sys) intRequest <= 1'b0;
		p[6] = q;
		for (int i = 6; i > 0; i--) begin
			iss(i == 6 ? CMD_INT_RETURN : CMD_RETURN, 13'h0000);
			chk(pcValue, p[i]);
		end
	endtask
	task automatic t_table();
		for (int i = 0; i < 4; i++) begin
			iss(psq_cmd_t'(4'h6 + i), 13'h0000);
			@(negedge clk_sys) chk(tableWrite.valid, 1'b1);
			chk({tableHighByteLatch, tableWrite.data}, 16'hBF06);
			chk(tableWrite.addr, i < 2 ? 12'h0A5 : 12'h3A5);
		end
		@(posedge clk_sys) regAddr <= REG_TABLE_HIGH;
		regWrData <= 8'hC3;
		regWr <= 1'b1;
		@(posedge clk_sys) regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge clk_sys) regRd <= 1'b0;
		@(negedge clk_sys) chk(regRdData, 8'hC3);
		chk(tableHighByteLatch, 8'hC3);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		t_flow();
		t_stack();
		t_table();
		summarize();
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			summarize();
		end
	end
endmodule
bind psq_sequencer psq_checker u_chk (.*);
